// file: design/dauc_pkg.sv
// Shared constants and types for the DAC update and clear control block.
// Assumes a 25 MHz system clock on both ends of the serial link.
//
// Summary of operation
// RQ1 - Strobe low: DAC updates on 32nd edge
// RQ2 - Async mode: strobe fall copies all registers
// RQ3 - Command 0010 writes then updates all
// RQ4 - Override bit 1 treats strobe as low
// RQ5 - Command 0110 loads the override register
// RQ6 - Override bits reset to zero
// RQ7 - Clear select picks zero, mid, full, none
// RQ8 - Command 0101 loads clear select from DB1:DB0
// RQ9 - Override DB1 is B, DB0 is A
// RQ10 - Frame: ignore, command, address, payload
// RQ11 - Host may tie strobe low or pulse
// RQ12 - Host holds sync low whole frame
// RQ13 - Byte hosts keep sync low between bytes
// RQ14 - Host sends MSB first, valid falling edge
// RQ15 - Clear fall loads code into all registers
// RQ16 - Clear during frame aborts that write
// RQ17 - Clear mode ends on next frame end
// RQ18 - Ignore strobe and clear during power-on
// RQ19 - Short frame is discarded entirely
package dauc_pkg;

  localparam int FRAME_BITS = 32;
  localparam int CNT_W      = 6;
  localparam int NCH        = 2;
  localparam int CODE_W     = 16;
  localparam int CMD_HI     = 27;
  localparam int CMD_LO     = 24;
  localparam int ADDR_HI    = 23;
  localparam int ADDR_LO    = 20;
  localparam int DATA_HI    = 19;
  localparam int DATA_LO    = 4;
  localparam int SEL_HI     = 1;
  localparam int SEL_LO     = 0;

  localparam logic [3:0] CMD_WR_IN      = 4'h0;
  localparam logic [3:0] CMD_UPD_N      = 4'h1;
  localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WR_UPD_N   = 4'h3;
  localparam logic [3:0] CMD_CLR_CODE   = 4'h5;
  localparam logic [3:0] CMD_OVERRIDE   = 4'h6;
  localparam logic [3:0] ADDR_ALL       = 4'hf;

  localparam logic [1:0] CLR_SEL_ZERO = 2'h0;
  localparam logic [1:0] CLR_SEL_MID  = 2'h1;
  localparam logic [1:0] CLR_SEL_FULL = 2'h2;
  localparam logic [1:0] CLR_SEL_NOP  = 2'h3;
  localparam logic [1:0] CLR_SEL_RST  = 2'h0;
  localparam logic [CODE_W-1:0] CLR_VAL_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CLR_VAL_MID  = 16'h8000;
  localparam logic [CODE_W-1:0] CLR_VAL_FULL = 16'hffff;
  localparam logic [CODE_W-1:0] CODE_RST     = 16'h0000;
  localparam logic [NCH-1:0]    OVR_RST      = 2'h0;

  // Pin positions in the device's synchroniser vector
  localparam int PIN_SCLK = 4;
  localparam int PIN_SYNC = 3;
  localparam int PIN_DIN  = 2;
  localparam int PIN_LD   = 1;
  localparam int PIN_CLR  = 0;
  localparam logic [4:0] PIN_IDLE = 5'h0b;

  localparam int CLK_PERIOD_NS  = 40;
  localparam int SCLK_PERIOD_NS = 320;
  localparam int STROBE_NS      = 160;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int STROBE_CYC     =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DST_IDLE  = 3'b001,
    DST_SHIFT = 3'b010,
    DST_WAIT  = 3'b100
  } dauc_dev_state_t;

  typedef enum logic [5:0] {
    HST_IDLE = 6'b000001,
    HST_LEAD = 6'b000010,
    HST_HIGH = 6'b000100,
    HST_LOW  = 6'b001000,
    HST_TAIL = 6'b010000,
    HST_GAP  = 6'b100000
  } dauc_host_state_t;

endpackage : dauc_pkg

// file: design/dauc_link_if.sv
// Three-wire serial link plus load strobe and clear pins.
// Host drives every wire; the device only listens.
`timescale 1ns/100ps
interface dauc_link_if;
  logic sclk;
  logic sync_n;
  logic din;
  logic load_strobe_n;
  logic clear_in_n;

  modport dev (
    input sclk,
    input sync_n,
    input din,
    input load_strobe_n,
    input clear_in_n
  );

  modport host (
    output sclk,
    output sync_n,
    output din,
    output load_strobe_n,
    output clear_in_n
  );
endinterface : dauc_link_if

// file: design/dauc_dev.sv
// Device end: frame receiver, input and DAC registers, override and
// clear-code registers. All link pins are asynchronous to clk.
`timescale 1ns/100ps
module dauc_dev
  import dauc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  dauc_link_if.dev                      link,
  input  wire logic                     por_busy,
  output logic [NCH-1:0][CODE_W-1:0]    dac_code,
  output logic [NCH-1:0][CODE_W-1:0]    input_code,
  output logic [NCH-1:0]                override_mask,
  output logic [1:0]                    clear_sel,
  output logic                          clear_active,
  output logic                          frame_done
);

  // Synchroniser: s1 feeds only s2; edges come from s2 against s3
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
    end else begin
      pin_s1 <= {link.sclk, link.sync_n, link.din,
                 link.load_strobe_n, link.clear_in_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  logic sclk_fall;
  logic sync_low;
  logic din_bit;
  logic ld_low;
  logic ld_fall;
  logic clr_fall;

  always_comb begin
    sclk_fall = pin_s3[PIN_SCLK] & ~pin_s2[PIN_SCLK];
    sync_low  = ~pin_s2[PIN_SYNC];
    din_bit   = pin_s2[PIN_DIN];
    // Load strobe and clear pins are masked while power-on reset runs
    ld_low    = ~pin_s2[PIN_LD] & ~por_busy; // RQ18
    ld_fall   = pin_s3[PIN_LD] & ~pin_s2[PIN_LD] & ~por_busy; // RQ18
    clr_fall  = pin_s3[PIN_CLR] & ~pin_s2[PIN_CLR] & ~por_busy; // RQ18
  end

  // Frame receiver
  dauc_dev_state_t       state;
  dauc_dev_state_t       next_state;
  logic [CNT_W-1:0]      cnt;
  logic [CNT_W-1:0]      next_cnt;
  logic [FRAME_BITS-1:0] shreg;
  logic [FRAME_BITS-1:0] next_shreg;
  logic                  next_done;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_shreg = shreg;
    next_done  = 1'b0;
    if (!sync_low) begin
      // Sync rising early drops the partial frame
      next_state = DST_IDLE; // RQ19
      next_cnt   = '0;
    end else if (clr_fall) begin
      // Rest of this frame is ignored until sync rises
      next_state = DST_WAIT; // RQ16
      next_cnt   = '0;
    end else begin
      case (state)
        DST_IDLE: begin
          next_cnt   = '0;
          next_state = DST_SHIFT;
        end
        DST_SHIFT: begin
          if (sclk_fall) begin
            next_shreg = {shreg[FRAME_BITS-2:0], din_bit};
            if (cnt == CNT_W'(FRAME_BITS - 1)) begin
              next_done  = 1'b1; // RQ1
              next_cnt   = '0;
              next_state = DST_WAIT;
            end else begin
              next_cnt = CNT_W'(cnt + 6'h01);
            end
          end
        end
        DST_WAIT: begin
          // Extra edges beyond 32 are ignored
          next_cnt = '0;
        end
        default: begin
          next_state = DST_IDLE;
          next_cnt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= DST_IDLE;
      cnt        <= '0;
      shreg      <= '0;
      frame_done <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      shreg      <= next_shreg;
      frame_done <= next_done;
    end
  end

  // Frame fields; valid while frame_done is high
  logic [3:0]        cmd;
  logic [3:0]        addr;
  logic [CODE_W-1:0] data;

  always_comb begin
    cmd  = shreg[CMD_HI:CMD_LO]; // RQ10
    addr = shreg[ADDR_HI:ADDR_LO]; // RQ10
    data = shreg[DATA_HI:DATA_LO]; // RQ10
  end

  // Control registers
  logic [NCH-1:0]    next_override;
  logic [1:0]        next_clear_sel;
  logic              next_clear_active;
  logic              clr_hit;
  logic [CODE_W-1:0] clear_val;

  always_comb begin
    next_override     = override_mask;
    next_clear_sel    = clear_sel;
    next_clear_active = clear_active;
    // Select 11 stops the clear pin loading codes or setting clear mode; it still aborts a frame
    clr_hit = clr_fall && (clear_sel != CLR_SEL_NOP); // RQ7
    case (clear_sel)
      CLR_SEL_ZERO: clear_val = CLR_VAL_ZERO; // RQ7
      CLR_SEL_MID:  clear_val = CLR_VAL_MID; // RQ7
      CLR_SEL_FULL: clear_val = CLR_VAL_FULL; // RQ7
      default:      clear_val = CLR_VAL_ZERO;
    endcase
    if (frame_done && cmd == CMD_OVERRIDE) begin
      // Only DB1 (B) and DB0 (A) exist; DB3:DB2 dropped
      next_override = shreg[NCH-1:0]; // RQ5 RQ9
    end
    if (frame_done && cmd == CMD_CLR_CODE) begin
      next_clear_sel = shreg[SEL_HI:SEL_LO]; // RQ8
    end
    if (frame_done) begin
      next_clear_active = 1'b0; // RQ17
    end
    // Set wins over a frame ending in the same cycle
    if (clr_hit) begin
      next_clear_active = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      override_mask <= OVR_RST; // RQ6
      clear_sel     <= CLR_SEL_RST;
      clear_active  <= 1'b0;
    end else begin
      override_mask <= next_override;
      clear_sel     <= next_clear_sel;
      clear_active  <= next_clear_active;
    end
  end

  // Per-channel input and DAC registers
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [CODE_W-1:0] in_q;
    logic [CODE_W-1:0] dac_q;
    logic [CODE_W-1:0] next_in;
    logic [CODE_W-1:0] next_dac;
    logic              sel;
    logic              wr;
    logic              upd;

    always_comb begin
      sel = (addr == 4'(i)) || (addr == ADDR_ALL);
      wr  = frame_done && sel &&
            (cmd == CMD_WR_IN || cmd == CMD_WR_UPD_ALL ||
             cmd == CMD_WR_UPD_N);
      upd = ld_fall // RQ2
         || (frame_done && cmd == CMD_WR_UPD_ALL) // RQ3
         || (frame_done && sel &&
             (cmd == CMD_UPD_N || cmd == CMD_WR_UPD_N))
         || (wr && (ld_low || override_mask[i])); // RQ1 RQ4 RQ11
      next_in  = wr ? data : in_q;
      next_dac = upd ? next_in : dac_q;
      if (clr_hit) begin
        next_in  = clear_val; // RQ15
        next_dac = clear_val; // RQ15
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        in_q  <= CODE_RST;
        dac_q <= CODE_RST;
      end else begin
        in_q  <= next_in;
        dac_q <= next_dac;
      end
    end

    assign dac_code[i]   = dac_q;
    assign input_code[i] = in_q;
  end

endmodule : dauc_dev

// file: design/dauc_host.sv
// Host end: shifts 32-bit frames out and drives the strobe pins.
// Serial clock is divided from clk; the device resamples every pin.
`timescale 1ns/100ps
module dauc_host
  import dauc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  dauc_link_if.host                  link,
  input  wire logic                  cmd_valid,
  input  wire logic [FRAME_BITS-1:0] cmd_word,
  output logic                       cmd_ready,
  input  wire logic                  load_tie_low,
  input  wire logic                  load_pulse_req,
  input  wire logic                  clear_pulse_req
);

  localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF_CYC - 1);
  localparam logic [2:0] STROBE_N  = 3'(STROBE_CYC);

  dauc_host_state_t      state;
  dauc_host_state_t      next_state;
  logic [2:0]            div;
  logic [2:0]            next_div;
  logic [CNT_W-1:0]      bitn;
  logic [CNT_W-1:0]      next_bitn;
  logic [FRAME_BITS-1:0] sh;
  logic [FRAME_BITS-1:0] next_sh;
  logic                  sclk_q;
  logic                  next_sclk;
  logic                  sync_q;
  logic                  next_sync;
  logic                  din_q;
  logic                  next_din;
  logic                  next_ready;
  logic                  half_done;

  always_comb begin
    next_state = state;
    next_bitn  = bitn;
    next_sh    = sh;
    next_sclk  = sclk_q;
    next_sync  = sync_q;
    next_din   = din_q;
    half_done  = (div == HALF_LAST);
    next_div   = half_done ? 3'h0 : 3'(div + 3'h1);
    case (state)
      HST_IDLE: begin
        next_div = 3'h0;
        if (cmd_valid) begin
          next_sh    = cmd_word;
          next_bitn  = '0;
          next_sync  = 1'b0; // RQ12
          next_state = HST_LEAD;
        end
      end
      HST_LEAD, HST_LOW: begin
        if (half_done) begin
          // Data changes on rising edge, steady at falling
          next_sclk  = 1'b1; // RQ14
          next_din   = sh[FRAME_BITS-1]; // RQ14
          next_sh    = {sh[FRAME_BITS-2:0], 1'b0};
          next_state = HST_HIGH;
        end
      end
      HST_HIGH: begin
        if (half_done) begin
          next_sclk = 1'b0;
          next_bitn = CNT_W'(bitn + 6'h01);
          // Sync stays low across all 32 bits
          next_state = (bitn == CNT_W'(FRAME_BITS - 1)) ?
                       HST_TAIL : HST_LOW; // RQ12 RQ13
        end
      end
      HST_TAIL: begin
        if (half_done) begin
          next_sync  = 1'b1;
          next_state = HST_GAP;
        end
      end
      HST_GAP: begin
        if (half_done) begin
          next_state = HST_IDLE;
        end
      end
      default: begin
        next_state = HST_IDLE;
        next_sclk  = 1'b0;
        next_sync  = 1'b1;
      end
    endcase
    next_ready = (next_state == HST_IDLE);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state     <= HST_IDLE;
      div       <= 3'h0;
      bitn      <= '0;
      sh        <= '0;
      sclk_q    <= 1'b0;
      sync_q    <= 1'b1;
      din_q     <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      state     <= next_state;
      div       <= next_div;
      bitn      <= next_bitn;
      sh        <= next_sh;
      sclk_q    <= next_sclk;
      sync_q    <= next_sync;
      din_q     <= next_din;
      cmd_ready <= next_ready;
    end
  end

  // Strobe pulses long enough to survive the device's resampling
  logic [2:0] ld_cnt;
  logic [2:0] next_ld_cnt;
  logic [2:0] clr_cnt;
  logic [2:0] next_clr_cnt;
  logic       ld_n_q;
  logic       next_ld_n;
  logic       clr_n_q;
  logic       next_clr_n;

  always_comb begin
    next_ld_cnt  = load_pulse_req ? STROBE_N :
                   (ld_cnt != 3'h0) ? 3'(ld_cnt - 3'h1) : 3'h0;
    next_clr_cnt = clear_pulse_req ? STROBE_N :
                   (clr_cnt != 3'h0) ? 3'(clr_cnt - 3'h1) : 3'h0;
    // Tie-low gives synchronous update; a pulse gives asynchronous update
    next_ld_n  = ~(load_tie_low || next_ld_cnt != 3'h0); // RQ11
    next_clr_n = (next_clr_cnt == 3'h0);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ld_cnt  <= 3'h0;
      clr_cnt <= 3'h0;
      ld_n_q  <= 1'b1;
      clr_n_q <= 1'b1;
    end else begin
      ld_cnt  <= next_ld_cnt;
      clr_cnt <= next_clr_cnt;
      ld_n_q  <= next_ld_n;
      clr_n_q <= next_clr_n;
    end
  end

  assign link.sclk          = sclk_q;
  assign link.sync_n        = sync_q;
  assign link.din           = din_q;
  assign link.load_strobe_n = ld_n_q;
  assign link.clear_in_n    = clr_n_q;

endmodule : dauc_host

// file: tb/dauc_chk.sv
// Link and device-output checker for the update and clear block.
// Instantiated by tb_top beside the link; one clock domain.
`timescale 1ns/100ps
module dauc_chk
  import dauc_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        nrst,
  input wire logic                        sclk,
  input wire logic                        sync_n,
  input wire logic                        din,
  input wire logic                        clear_in_n,
  input wire logic                        por_busy,
  input wire logic [NCH-1:0][CODE_W-1:0]  dac_code,
  input wire logic [NCH-1:0]              override_mask,
  input wire logic [1:0]                  clear_sel,
  input wire logic                        clear_active,
  input wire logic                        frame_done
);
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic              sclk_q;
  logic              next_sclk_q;
  logic [CODE_W-1:0] clr_val;

  // Rises of the serial clock inside one frame
  always_comb begin
    next_sclk_q = sclk;
    next_cnt    = sync_n ? '0 : cnt + CNT_W'(sclk & ~sclk_q);
    clr_val     = clear_sel[1] ? 16'hffff : {clear_sel[0], 15'h0000};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt    <= '0;
      sclk_q <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      sclk_q <= next_sclk_q;
    end
  end

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_lead;
    $fell(sync_n) |-> !sclk [*4] ##1 sclk;
  endproperty
  a_lead: assert property (p_lead)
    else $error("sync lead wrong");
  property p_high;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_high: assert property (p_high)
    else $error("sclk high width wrong");
  property p_din;
    $rose(sclk) |=> $stable(din) [*4];
  endproperty
  a_din: assert property (p_din)
    else $error("din moved before falling edge");
  property p_count;
    $rose(sync_n) |-> cnt == CNT_W'(FRAME_BITS);
  endproperty
  a_count: assert property (p_count)
    else $error("frame edge count wrong");
  property p_clrw;
    $fell(clear_in_n) |-> !clear_in_n [*4] ##1 clear_in_n;
  endproperty
  a_clrw: assert property (p_clrw)
    else $error("clear pulse width wrong");
  property p_clr;
    $fell(clear_in_n) && !por_busy && clear_sel != 2'h3 |->
      ##[1:5] (clear_active && dac_code[0] == clr_val &&
               dac_code[1] == clr_val);
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear code not loaded");
  property p_exit;
    frame_done && clear_in_n |=> !clear_active;
  endproperty
  a_exit: assert property (p_exit)
    else $error("clear mode kept after frame");
  property p_ovr;
    !frame_done |=> $stable(override_mask);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("override changed without frame");
endmodule : dauc_chk

// file: tb/tb_top.sv
// Top bench: host and device joined by the link, and a second device
// fed straight from the bench for short and byte-paused frames.
`timescale 1ns/100ps
module tb_top
  import dauc_pkg::*;
;
  logic                       clk;
  logic                       nrst;
  logic                       cmd_valid;
  logic [FRAME_BITS-1:0]      cmd_word;
  logic                       cmd_ready;
  logic                       load_tie_low;
  logic                       load_pulse_req;
  logic                       clear_pulse_req;
  logic                       por_busy;
  logic [NCH-1:0][CODE_W-1:0] dac_code;
  logic [NCH-1:0][CODE_W-1:0] input_code;
  logic [NCH-1:0][CODE_W-1:0] dac_code2;
  logic [NCH-1:0]             override_mask;
  logic [NCH-1:0]             override_mask2;
  logic [1:0]                 clear_sel;
  logic                       clear_active;
  logic                       frame_done;
  logic [15:0]                clr_tab [4] = '{16'h0000, 16'h8000,
                                              16'hffff, 16'h5a5a};
  int                         err_total = 0;
  int                         check_count = 0;

  dauc_link_if link ();
  dauc_link_if link2 ();

  dauc_host dauc_host_inst (.clk, .nrst, .link, .cmd_valid, .cmd_word,
    .cmd_ready, .load_tie_low, .load_pulse_req, .clear_pulse_req);
  dauc_dev dauc_dev_inst (.clk, .nrst, .link, .por_busy, .dac_code,
    .input_code, .override_mask, .clear_sel, .clear_active, .frame_done);
  dauc_dev dauc_dev_inst2 (.clk, .nrst, .link(link2), .por_busy(1'b0),
    .dac_code(dac_code2), .input_code(), .override_mask(override_mask2),
    .clear_sel(), .clear_active(), .frame_done());
  dauc_chk dauc_chk_inst (.clk, .nrst, .sclk(link.sclk),
    .sync_n(link.sync_n), .din(link.din), .clear_in_n(link.clear_in_n),
    .por_busy, .dac_code, .override_mask, .clear_sel, .clear_active,
    .frame_done);

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  function automatic logic [31:0] fr(input logic [3:0] c,
    input logic [3:0] a, input logic [15:0] d, input logic [3:0] l);
    return {4'ha, c, a, d, l};
  endfunction : fr

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic pulse(input bit c);
    if (c)
      clear_pulse_req = 1'b1;
    else
      load_pulse_req = 1'b1;
    tick(1);
    clear_pulse_req = 1'b0;
    load_pulse_req  = 1'b0;
    tick(8);
  endtask : pulse

  // Clear pulse mid-frame when clr_at is above zero
  task automatic send(input logic [31:0] w, input int clr_at);
    int k;
    k         = 0;
    cmd_word  = w;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    tick(1);
    cmd_valid = 1'b0;
    tick(2);
    if (clr_at > 0) begin
      tick(clr_at);
      pulse(1'b1);
    end
    k = 0;
    while (cmd_ready !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    tick(2);
  endtask : send

  // Bench as host on the second link; data inverted after sync rises
  task automatic bang(input logic [31:0] w, input int n);
    link2.sync_n = 1'b0;
    tick(2);
    for (int i = 31; i > 31 - n; i--) begin
      link2.din  = w[i];
      link2.sclk = 1'b1;
      tick(4);
      link2.sclk = 1'b0;
      tick(4);
      if (i % 8 == 0)
        tick(6);
    end
    link2.sync_n = 1'b1;
    link2.din    = ~link2.din;
    tick(8);
  endtask : bang

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("BAD watchdog exp done got hang");
    tally_and_finish();
  end

  initial begin
    clk                 = 1'b0;
    nrst                = 1'b0;
    cmd_valid           = 1'b0;
    cmd_word            = '0;
    load_tie_low        = 1'b0;
    load_pulse_req      = 1'b0;
    clear_pulse_req     = 1'b0;
    por_busy            = 1'b0;
    link2.sclk          = 1'b0;
    link2.sync_n        = 1'b1;
    link2.din           = 1'b0;
    link2.load_strobe_n = 1'b1;
    link2.clear_in_n    = 1'b1;
    tick(2);
    nrst = 1'b1;
    tick(2);
    chk("ovr", 16'h0, 16'(override_mask));
    $display("T1 reset done");
    send(fr(CMD_WR_IN, 4'h0, 16'h1234, 4'h0), 0);
    send(fr(CMD_WR_IN, 4'h1, 16'h5678, 4'h0), 0);
    chk("in_a", 16'h1234, input_code[0]);
    chk("dac_b", 16'h0000, dac_code[1]);
    pulse(1'b0);
    chk("dac_a", 16'h1234, dac_code[0]);
    chk("dac_b", 16'h5678, dac_code[1]);
    $display("T2 strobe load done");
    load_tie_low = 1'b1;
    tick(4);
    send(fr(CMD_WR_IN, 4'h0, 16'habcd, 4'h0), 0);
    chk("dac_a", 16'habcd, dac_code[0]);
    load_tie_low = 1'b0;
    tick(4);
    send(fr(CMD_WR_IN, 4'h0, 16'h1111, 4'h0), 0);
    chk("dac_a", 16'habcd, dac_code[0]);
    send(fr(CMD_WR_UPD_ALL, 4'h1, 16'h4321, 4'h0), 0);
    chk("dac_a", 16'h1111, dac_code[0]);
    chk("dac_b", 16'h4321, dac_code[1]);
    $display("T3 sync and soft load done");
    send(fr(CMD_OVERRIDE, 4'h3, 16'hffff, 4'he), 0);
    chk("ovr", 16'h2, 16'(override_mask));
    send(fr(CMD_WR_IN, ADDR_ALL, 16'h2222, 4'h0), 0);
    chk("dac_a", 16'h1111, dac_code[0]);
    chk("dac_b", 16'h2222, dac_code[1]);
    send(fr(CMD_OVERRIDE, 4'h0, 16'h0000, 4'h0), 0);
    chk("ovr", 16'h0, 16'(override_mask));
    $display("T4 override done");
    for (int s = 0; s < 4; s++) begin
      send(fr(CMD_CLR_CODE, 4'h9, 16'hffff, {2'h3, 2'(s)}), 0);
      chk("sel", 16'(s), 16'(clear_sel));
      send(fr(CMD_WR_UPD_N, ADDR_ALL, 16'h5a5a, 4'h0), 0);
      pulse(1'b1);
      chk("dac_a", clr_tab[s], dac_code[0]);
      chk("in_b", clr_tab[s], input_code[1]);
      chk("clr_act", 16'(s < 3), 16'(clear_active));
      send(fr(4'hd, 4'h0, 16'h0000, 4'h0), 0);
      chk("clr_act", 16'h0, 16'(clear_active));
    end
    $display("T5 clear codes done");
    send(fr(CMD_WR_UPD_N, ADDR_ALL, 16'h7777, 4'h0), 100);
    chk("in_a", 16'h5a5a, input_code[0]);
    chk("dac_b", 16'h5a5a, dac_code[1]);
    send(fr(CMD_CLR_CODE, 4'h0, 16'h0000, 4'h1), 0);
    send(fr(CMD_WR_IN, 4'h0, 16'h0bad, 4'h0), 0);
    por_busy = 1'b1;
    tick(2);
    pulse(1'b0);
    pulse(1'b1);
    por_busy = 1'b0;
    tick(2);
    chk("dac_a", 16'h5a5a, dac_code[0]);
    chk("clr_act", 16'h0, 16'(clear_active));
    pulse(1'b0);
    chk("dac_a", 16'h0bad, dac_code[0]);
    $display("T6 abort and power-on mask done");
    bang(fr(CMD_OVERRIDE, 4'h0, 16'h0000, 4'h3), 31);
    chk("ovr2", 16'h0, 16'(override_mask2));
    bang(fr(CMD_WR_UPD_N, 4'h0, 16'h8001, 4'h0), 32);
    chk("dac2_a", 16'h8001, dac_code2[0]);
    chk("dac2_b", 16'h0000, dac_code2[1]);
    chk("ovr2", 16'h0, 16'(override_mask2));
    $display("T7 bench frames done");
    tally_and_finish();
  end
endmodule : tb_top
